// ### rtl/pjg_port_j.v
// Eight-bit general purpose port with external bus override and Avalon-MM registers
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`include "pjg_regs.vh"

// Summary of operation
// - Eight independent bidirectional pins
// - Direction bit one floats the pin
// - Direction bit zero drives latch value
// - Per-pin direction, hysteresis-buffered inputs
// - Latch reads return latch, not pins
// - Reset makes all pins inputs
// - Clearing bus disable hands pins to interface
// - Interface overrides direction and port data
// - Bits 0-3: ALE, OE, write strobes
// - Bits 4-7: address bit, CE, byte enables
// - Shared control bit gates all pull-ups
// - Output pins lose their pull-up
// - Reset leaves pull-ups disabled
module pjg_port_j #(
    parameter WIDTH = 8
) (
    // Clocking
    input  wire             clk,
    input  wire             reset,
    input  wire             clkEn,
    // Avalon-MM slave
    input  wire [4:0]       avsAddress,
    input  wire             avsRead,
    input  wire             avsWrite,
    input  wire [31:0]      avsWritedata,
    input  wire [3:0]       avsByteenable,
    output reg  [31:0]      avsReaddata,
    output reg              avsWaitrequest,
    output reg  [1:0]       avsResponse,
    // Memory interface control sources
    input  wire             memAddrLatchEn,
    input  wire             memOutputEn,
    input  wire             memWriteLowStrobe,
    input  wire             memWriteHighStrobe,
    input  wire             memByteAddressBit,
    input  wire             memChipEn,
    input  wire             memLowerByteEnable,
    input  wire             memUpperByteEnable,
    // Pins
    input  wire [WIDTH-1:0] pinIn,
    output reg  [WIDTH-1:0] pinOut,
    output reg  [WIDTH-1:0] pinOe,
    output reg  [WIDTH-1:0] pinPullupEn
);
    // ==========================================================
    // Registers
    reg  [WIDTH-1:0] outputLatch_r;
    reg  [WIDTH-1:0] pinDirection_r;
    reg  [7:0]       portGCtrl_r;
    reg  [7:0]       memIfCtrl_r;
    reg              ackPending_r;
    wire [WIDTH-1:0] pinLevel;
    wire [WIDTH-1:0] pinOutNxt;
    wire [WIDTH-1:0] pinOeNxt;
    wire [WIDTH-1:0] pullupNxt;
    wire [WIDTH-1:0] memCtrlBus;
    wire             memIfOwns;
    wire             accessReq;
    wire             accessDone;
    reg  [7:0]       readByte;

    // Merge one byte lane of write data under byte enable
    function [7:0] laneMerge;
        input [7:0] oldVal;
        input [7:0] newVal;
        input       laneEn;
        begin
            laneMerge = laneEn ? newVal : oldVal;
        end
    endfunction

    function mapped;
        input [4:0] addr;
        begin
            mapped = (addr == {1'b0, `PJG_OFF_PIN_LEVEL_DATA}) || (addr == {1'b0, `PJG_OFF_OUTPUT_LATCH}) ||
                     (addr == {1'b0, `PJG_OFF_PIN_DIRECTION}) || (addr == {1'b0, `PJG_OFF_PORT_G_CTRL}) ||
                     (addr == `PJG_OFF_MEM_IF_CTRL);
        end
    endfunction

    // ==========================================================
    // Pin sampling through two flops (hysteresis lives in the pad)
    pjg_sync2 #(
        .WIDTH   (WIDTH)
    ) uSync (
        .clk     (clk),
        .reset   (reset),
        .clkEn   (clkEn),
        .asyncIn (pinIn),
        .syncOut (pinLevel)
    );

    // ==========================================================
    // Memory interface control placement
    assign memCtrlBus = {memUpperByteEnable, memLowerByteEnable, memChipEn, memByteAddressBit,
                         memWriteHighStrobe, memWriteLowStrobe, memOutputEn, memAddrLatchEn};
    assign memIfOwns  = ~memIfCtrl_r[`PJG_BIT_EXT_BUS_DISABLE];

    pjg_pin_mux #(
        .WIDTH      (WIDTH)
    ) uMux (
        .latchVal   (outputLatch_r),
        .dirVal     (pinDirection_r),
        .pullupCtrl (portGCtrl_r[`PJG_BIT_PULLUP_ENABLE]),
        .memIfOwns  (memIfOwns),
        .memIfCtrl  (memCtrlBus),
        .pinOutNxt  (pinOutNxt),
        .pinOeNxt   (pinOeNxt),
        .pullupNxt  (pullupNxt)
    );

    // Registered pin drive, one cycle behind the control state
    always @(posedge clk) begin
        if (reset) begin
            pinOut      <= {WIDTH{1'b0}};
            pinOe       <= {WIDTH{1'b0}};
            pinPullupEn <= {WIDTH{1'b0}};
        end else if (clkEn) begin
            pinOut      <= pinOutNxt;
            pinOe       <= pinOeNxt;
            pinPullupEn <= pullupNxt;
        end
    end

    // ==========================================================
    // Avalon-MM slave: one wait state, answer on the second edge
    // Waitrequest stays combinational so a low clock enable holds the master off
    assign accessReq  = avsRead | avsWrite;
    assign accessDone = accessReq & ackPending_r & clkEn;

    always @(posedge clk) begin
        if (reset) begin
            ackPending_r <= 1'b0;
        end else if (clkEn) begin
            ackPending_r <= accessReq & ~ackPending_r;
        end
    end

    always @* begin
        avsWaitrequest = ~accessDone;
    end

    always @(posedge clk) begin
        if (reset) begin
            outputLatch_r  <= `PJG_RST_OUTPUT_LATCH;
            pinDirection_r <= `PJG_RST_PIN_DIRECTION;
            portGCtrl_r    <= `PJG_RST_PORT_G_CTRL;
            memIfCtrl_r    <= `PJG_RST_MEM_IF_CTRL;
        end else if (clkEn && avsWrite && accessDone) begin
            case (avsAddress)
                {1'b0, `PJG_OFF_PIN_LEVEL_DATA},
                {1'b0, `PJG_OFF_OUTPUT_LATCH}: begin
                    outputLatch_r <= laneMerge(outputLatch_r, avsWritedata[7:0], avsByteenable[0]);
                end
                {1'b0, `PJG_OFF_PIN_DIRECTION}: begin
                    pinDirection_r <= laneMerge(pinDirection_r, avsWritedata[7:0], avsByteenable[0]);
                end
                {1'b0, `PJG_OFF_PORT_G_CTRL}: begin
                    portGCtrl_r <= laneMerge(portGCtrl_r, avsWritedata[7:0], avsByteenable[0]);
                end
                `PJG_OFF_MEM_IF_CTRL: begin
                    memIfCtrl_r <= laneMerge(memIfCtrl_r, avsWritedata[7:0], avsByteenable[0]);
                end
                default: begin
                end
            endcase
        end
    end

    // Read byte selection
    always @* begin
        case (avsAddress)
            {1'b0, `PJG_OFF_PIN_LEVEL_DATA}: readByte = pinLevel;
            {1'b0, `PJG_OFF_OUTPUT_LATCH}:   readByte = outputLatch_r;
            {1'b0, `PJG_OFF_PIN_DIRECTION}:  readByte = pinDirection_r;
            {1'b0, `PJG_OFF_PORT_G_CTRL}:    readByte = portGCtrl_r;
            `PJG_OFF_MEM_IF_CTRL:            readByte = memIfCtrl_r;
            default:                         readByte = 8'h00;
        endcase
    end

    // Read data captured at the first edge of the access, so it stands in the cycle that waitrequest is low
    always @(posedge clk) begin
        if (reset) begin
            avsReaddata <= 32'h0000_0000;
            avsResponse <= 2'h0;
        end else if (clkEn && accessReq && !ackPending_r) begin
            avsReaddata <= {24'h000000, readByte};
            avsResponse <= mapped(avsAddress) ? 2'h0 : 2'h2;
        end
    end
endmodule // pjg_port_j

// ### rtl/pjg_regs.vh
// Register offsets, field positions and reset values of the port block
`ifndef PJG_REGS_VH
`define PJG_REGS_VH

// ==========================================================
// Register byte offsets (Avalon word aligned)
`define PJG_OFF_PIN_LEVEL_DATA 4'h0
`define PJG_OFF_OUTPUT_LATCH   4'h4
`define PJG_OFF_PIN_DIRECTION  4'h8
`define PJG_OFF_PORT_G_CTRL    4'hC
`define PJG_OFF_MEM_IF_CTRL    5'h10

// ==========================================================
// Field positions
`define PJG_BIT_PULLUP_ENABLE   5
`define PJG_BIT_EXT_BUS_DISABLE 7

// ==========================================================
// Reset values
`define PJG_RST_OUTPUT_LATCH   8'h00
`define PJG_RST_PIN_DIRECTION  8'hFF
`define PJG_RST_PORT_G_CTRL    8'h00
`define PJG_RST_MEM_IF_CTRL    8'h80

`endif

// ### rtl/pjg_sync2.v
// Two-flop synchroniser for the pin inputs
module pjg_sync2 #(
    parameter WIDTH = 8
) (
    // Clocking
    input  wire             clk,
    input  wire             reset,
    input  wire             clkEn,
    // Data
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_r;

    always @(posedge clk) begin
        if (reset) begin
            stage1_r <= {WIDTH{1'b0}};
            syncOut  <= {WIDTH{1'b0}};
        end else if (clkEn) begin
            stage1_r <= asyncIn;
            syncOut  <= stage1_r;
        end
    end
endmodule // pjg_sync2

// ### rtl/pjg_pin_mux.v
// Per-pin owner mux: port function or memory interface control outputs
module pjg_pin_mux #(
    parameter WIDTH = 8
) (
    // Port side
    input  wire [WIDTH-1:0] latchVal,
    input  wire [WIDTH-1:0] dirVal,
    input  wire             pullupCtrl,
    // Memory interface side
    input  wire             memIfOwns,
    input  wire [WIDTH-1:0] memIfCtrl,
    // Pin side
    output wire [WIDTH-1:0] pinOutNxt,
    output wire [WIDTH-1:0] pinOeNxt,
    output wire [WIDTH-1:0] pullupNxt
);
    // Memory interface wins, direction ignored
    assign pinOutNxt = memIfOwns ? memIfCtrl : latchVal;
    assign pinOeNxt  = memIfOwns ? {WIDTH{1'b1}} : ~dirVal;
    // Pull-up only on pins that are not driven
    assign pullupNxt = {WIDTH{pullupCtrl}} & ~pinOeNxt;
endmodule // pjg_pin_mux

// ### bench/pjg_checker.sv
// Assertion checker for the port block
module pjg_checker #(
    parameter WIDTH = 8
) (
    // Bus
    input logic clk,
    input logic reset,
    input logic clkEn,
    input logic [4:0] avsAddress,
    input logic avsRead,
    input logic avsWrite,
    input logic [31:0] avsWritedata,
    input logic [3:0] avsByteenable,
    input logic [31:0] avsReaddata,
    input logic avsWaitrequest,
    // Memory interface
    input logic memAddrLatchEn,
    input logic memOutputEn,
    input logic memWriteLowStrobe,
    input logic memWriteHighStrobe,
    input logic memByteAddressBit,
    input logic memChipEn,
    input logic memLowerByteEnable,
    input logic memUpperByteEnable,
    // Pins
    input logic [WIDTH-1:0] pinOut,
    input logic [WIDTH-1:0] pinOe,
    input logic [WIDTH-1:0] pinPullupEn
);
    // ====
    // Shadow registers
    logic [7:0] latR, dirR;
    logic ownR, puR;
    always @(posedge clk) begin
        if (reset) begin
            {latR, dirR, ownR, puR} <= 18'h003FC;
        end else if (avsWrite && !avsWaitrequest && clkEn && avsByteenable[0]) begin
            case (avsAddress)
                5'h00, 5'h04: latR <= avsWritedata[7:0];
                5'h08: dirR <= avsWritedata[7:0];
                5'h0C: puR <= avsWritedata[5];
                5'h10: ownR <= !avsWritedata[7];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_latRd; avsRead && !avsWaitrequest && avsAddress == 5'h04; endsequence
    property p_rst; disable iff (1'b0) reset |=> pinOe == 8'h00 && pinPullupEn == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("pins not inputs after reset");
    property p_oe; !ownR |=> pinOe == ~$past(dirR); endproperty
    a_oe: assert property (p_oe) else $error("pin enable differs from direction");
    property p_out; !ownR |=> (pinOut & pinOe) == ($past(latR) & pinOe); endproperty
    a_out: assert property (p_out) else $error("driven pin differs from latch");
    property p_own; ownR |=> pinOe == 8'hFF && pinPullupEn == 8'h00; endproperty
    a_own: assert property (p_own) else $error("bus mode not driving all pins");
    property p_lo; ownR |=> pinOut[3:0] == $past({memWriteHighStrobe, memWriteLowStrobe, memOutputEn, memAddrLatchEn});
    endproperty
    a_lo: assert property (p_lo) else $error("low nibble bus mapping wrong");
    property p_hi; ownR |=> pinOut[7:4] == $past({memUpperByteEnable, memLowerByteEnable, memChipEn, memByteAddressBit});
    endproperty
    a_hi: assert property (p_hi) else $error("high nibble bus mapping wrong");
    property p_pu; !ownR |=> pinPullupEn == ($past(puR) ? $past(dirR) : 8'h00); endproperty
    a_pu: assert property (p_pu) else $error("pull-up enables wrong");
    property p_latRd; s_latRd |-> avsReaddata == {24'h000000, latR}; endproperty
    a_latRd: assert property (p_latRd) else $error("latch readback wrong");
endmodule // pjg_checker

bind pjg_port_j pjg_checker #(.WIDTH(WIDTH)) i_chk (.*);

// ### bench/pjg_pin_model.sv
// Pad model: external drivers, weak pull-ups, floating pads
module pjg_pin_model (
    input logic clk,
    input logic [7:0] pinOut,
    input logic [7:0] pinOe,
    input logic [7:0] pinPullupEn,
    input logic [7:0] extVal,
    input logic [7:0] extEn,
    output logic [7:0] pinIn
);
    // ====
    // Undriven pads wander so no stale value reads as valid
    logic [7:0] fltR = 8'h00;
    always @(posedge clk) fltR <= ~fltR;
    assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn & (pinPullupEn | fltR));
endmodule // pjg_pin_model

// ### bench/tb_port_j_gpio_with_bus_override.sv
// Self-checking bench for the port block
module tb_port_j_gpio_with_bus_override;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Signals
    logic clk = 0, reset = 1, clkEn = 1, avsRead = 0, avsWrite = 0;
    logic [4:0] avsAddress = 5'h00;
    logic [31:0] avsWritedata = 32'h0, avsReaddata, rdVal;
    logic [3:0] avsByteenable = 4'hF;
    logic avsWaitrequest;
    logic [1:0] avsResponse, rsp;
    logic [7:0] pinIn, pinOut, pinOe, pinPullupEn, memBus = 8'h00, extVal = 8'h03, extEn = 8'h0F;
    wire memAddrLatchEn, memOutputEn, memWriteLowStrobe, memWriteHighStrobe;
    wire memByteAddressBit, memChipEn, memLowerByteEnable, memUpperByteEnable;
    assign {memUpperByteEnable, memLowerByteEnable, memChipEn, memByteAddressBit} = memBus[7:4];
    assign {memWriteHighStrobe, memWriteLowStrobe, memOutputEn, memAddrLatchEn} = memBus[3:0];
    int err_total = 0, checks = 0, cyc = 0;
    pjg_port_j i_dut (.*);
    pjg_pin_model i_pins (.*);
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            err_total++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Avalon access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWritedata <= {24'h000000, d};
        avsWrite <= w;
        avsRead <= !w;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        rdVal = avsReaddata;
        rsp = avsResponse;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk("readdata", {24'h000000, e}, rdVal);
    endtask
    task automatic settle;
        repeat (4) @(negedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        settle();
        chk("pinOe", 8'h00, pinOe);
        chk("pinPullupEn", 8'h00, pinPullupEn);
        chk("pinOut", 8'h00, pinOut);
        rd(5'h04, 8'h00);
        rd(5'h08, 8'hFF);
        rd(5'h10, 8'h80);
        acc(1'b1, 5'h0C, 8'h20);
        settle();
        chk("pinPullupEn", 8'hFF, pinPullupEn);
        rd(5'h00, 8'hF3);
        acc(1'b1, 5'h00, 8'hA5);
        acc(1'b1, 5'h08, 8'h0F);
        settle();
        chk("pinOe", 8'hF0, pinOe);
        chk("pinOut", 8'hA0, pinOut & 8'hF0);
        chk("pinPullupEn", 8'h0F, pinPullupEn);
        rd(5'h00, 8'hA3);
        rd(5'h04, 8'hA5);
        acc(1'b1, 5'h0C, 8'h00);
        settle();
        chk("pinPullupEn", 8'h00, pinPullupEn);
        acc(1'b1, 5'h10, 8'h00);
        settle();
        chk("pinOe", 8'hFF, pinOe);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            memBus <= 8'h01 << i;
            repeat (2) @(negedge clk);
            chk("pinOut", 8'h01 << i, pinOut);
        end
        acc(1'b0, 5'h14, 8'h00);
        chk("response", 2'h2, rsp);
        acc(1'b1, 5'h10, 8'h80);
        settle();
        chk("pinOe", 8'hF0, pinOe);
        // Low clock enable must stall a write until it returns
        fork
            acc(1'b1, 5'h04, 8'h3C);
            begin
                @(posedge clk);
                clkEn <= 1'b0;
                repeat (4) @(negedge clk);
                chk("waitrequest", 32'h1, {31'h0, avsWaitrequest});
                @(posedge clk);
                clkEn <= 1'b1;
            end
        join
        settle();
        chk("pinOut", 8'h30, pinOut & 8'hF0);
        // Lane 0 disabled leaves the latch alone
        avsByteenable <= 4'hE;
        acc(1'b1, 5'h04, 8'hFF);
        avsByteenable <= 4'hF;
        rd(5'h04, 8'h3C);
        // Reset in mid-run with pull-ups and outputs active
        acc(1'b1, 5'h0C, 8'h20);
        settle();
        chk("pinPullupEn", 8'h0F, pinPullupEn);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        settle();
        chk("pinOe", 8'h00, pinOe);
        chk("pinPullupEn", 8'h00, pinPullupEn);
        rd(5'h08, 8'hFF);
        rd(5'h0C, 8'h00);
        results();
    end
endmodule // tb_port_j_gpio_with_bus_override
